// File: design/sfsp_status_protect.v
/*
 * Status register and protection logic of a serial NOR flash: write
 * enable latch, busy flag, block protect, status protect / OTP lock,
 * pin disable, quad command mode, and the status read and write commands.
 * Assumes link pins synchronous to clk_in and an array engine outside that
 * asks for permission and reports busy and completion.
 */
`timescale 1ns/1ns
`include "sfsp_defs.vh"

module sfsp_status_protect #(
    parameter [31:0] STATUS_WRITE_CYCLES = `SFSP_STATUS_WRITE_CYCLES
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Serial link
    input wire cs_n_in,
    input wire sclk_in,
    input wire [3:0] dq_in,
    output wire [3:0] dq_out,
    output wire [3:0] dq_oe_out,
    // Hold pin function
    output wire hold_active_out,
    // OTP mode control
    input wire otp_enter_in,
    output wire otp_mode_out,
    // Array operation permission
    input wire op_req_in,
    input wire op_chip_erase_in,
    input wire op_hits_protect_in,
    input wire op_otp_sector_in,
    output wire op_grant_out,
    output wire op_reject_out,
    // Array operation progress
    input wire array_busy_in,
    input wire array_done_in,
    // Status view
    output wire [7:0] status_out,
    output wire quad_mode_out,
    output wire hw_protect_out
);

// ----------------------------------------------------------------------
// State of the status read output
// ----------------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_READ = 3'b010;
localparam [2:0] ST_SKIP = 3'b100;

reg [2:0] state_reg;
reg [2:0] state_next;

// ----------------------------------------------------------------------
// Status storage
// ----------------------------------------------------------------------
reg protect_reg;
reg pin_disable_reg;
reg [3:0] block_protect_reg;
reg write_enable_latch_reg;
reg otp_lock_reg;
reg otp_mode_reg;
reg quad_mode_reg;
reg [7:0] out_shift_reg;
reg [2:0] out_count_reg;
reg [3:0] dq_out_reg;
reg [3:0] dq_oe_reg;
reg [7:0] opcode_reg;
reg grant_reg;
reg reject_reg;
reg write_status_cmd_start_reg;

wire [15:0] rx_shift;
wire [5:0] rx_count;
wire opcode_strobe;
wire cs_rise;
wire sclk_fall;
wire write_status_cmd_busy;
wire write_status_cmd_done;
wire busy_flag;
wire hardware_protected_mode;
wire [7:0] status_byte;
wire frame_opcode_only;
wire frame_write_status_cmd;
wire write_status_cmd_ok;
wire op_ok;
wire [5:0] nv_reset_value;

// ----------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------
function [7:0] pack_status;
    input top_bit;
    input pin_dis;
    input [3:0] bp;
    input write_enable_latch;
    input busy;
    begin
        pack_status = {top_bit, pin_dis, bp, write_enable_latch, busy};
    end
endfunction

function is_opcode;
    input [7:0] code;
    input [7:0] want;
    begin
        is_opcode = (code == want);
    end
endfunction

// ----------------------------------------------------------------------
// Submodules
// ----------------------------------------------------------------------
sfsp_link_rx u_rx (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .cs_n_in(cs_n_in),
    .sclk_in(sclk_in),
    .dq_in(dq_in),
    .quad_in(quad_mode_reg),
    .shift_out(rx_shift),
    .bit_count_out(rx_count),
    .opcode_strobe_out(opcode_strobe),
    .cs_rise_out(cs_rise),
    .sclk_fall_out(sclk_fall)
);

sfsp_write_timer #(
    .CYCLES(STATUS_WRITE_CYCLES)
) u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(write_status_cmd_start_reg),
    .busy_out(write_status_cmd_busy),
    .done_out(write_status_cmd_done)
);

// ----------------------------------------------------------------------
// Derived status
// ----------------------------------------------------------------------
assign busy_flag = write_status_cmd_busy | write_status_cmd_start_reg | array_busy_in;
// Protect pin is DQ2; pins ignored when disabled or carrying quad data
assign hardware_protected_mode = protect_reg & ~dq_in[2] & ~pin_disable_reg & ~quad_mode_reg;
assign hold_active_out = ~pin_disable_reg & ~quad_mode_reg & ~dq_in[3] & ~cs_n_in;
assign status_byte = pack_status(otp_mode_reg ? otp_lock_reg : protect_reg, pin_disable_reg,
                                 block_protect_reg, write_enable_latch_reg, busy_flag);
assign status_out = status_byte;
assign nv_reset_value = `SFSP_NV_RESET;
assign quad_mode_out = quad_mode_reg;
assign hw_protect_out = hardware_protected_mode;
assign otp_mode_out = otp_mode_reg;
assign dq_out = dq_out_reg;
assign dq_oe_out = dq_oe_reg;
assign op_grant_out = grant_reg;
assign op_reject_out = reject_reg;

assign frame_opcode_only = cs_rise & (rx_count == `SFSP_OPCODE_BITS);
assign frame_write_status_cmd = cs_rise & (rx_count == `SFSP_WRITE_STATUS_CMD_BITS) &
                    is_opcode(rx_shift[15:8], `SFSP_OP_WRITE_STATUS);
assign write_status_cmd_ok = frame_write_status_cmd & write_enable_latch_reg & ~busy_flag &
                 ~hardware_protected_mode;

// Array operation checks: latch, busy, range, chip erase, OTP lock
assign op_ok = write_enable_latch_reg & ~busy_flag &
               ~(op_hits_protect_in & (block_protect_reg != 4'h0)) &
               ~(op_chip_erase_in & (block_protect_reg != 4'h0)) &
               ~(op_otp_sector_in & otp_mode_reg & otp_lock_reg);

// ----------------------------------------------------------------------
// Status read shifter state
// ----------------------------------------------------------------------
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (opcode_strobe) begin
                if (is_opcode(rx_shift[7:0], `SFSP_OP_READ_STATUS)) begin
                    state_next = ST_READ;
                end else begin
                    state_next = ST_SKIP;
                end
            end
        end
        ST_READ: begin
            if (cs_n_in) begin
                state_next = ST_IDLE;
            end
        end
        ST_SKIP: begin
            if (cs_n_in) begin
                state_next = ST_IDLE;
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
    if (cs_n_in) begin
        state_next = ST_IDLE;
    end
end

// ----------------------------------------------------------------------
// Output shifting on falling serial clock
// ----------------------------------------------------------------------
always @(posedge clk_in) begin
    if (reset_in) begin
        state_reg <= ST_IDLE;
        out_shift_reg <= 8'h00;
        out_count_reg <= 3'h0;
        dq_out_reg <= 4'h0;
        dq_oe_reg <= 4'h0;
    end else begin
        state_reg <= state_next;
        if (cs_n_in || state_reg != ST_READ) begin
            out_count_reg <= 3'h0;
            dq_oe_reg <= 4'h0;
            dq_out_reg <= 4'h0;
        end else if (sclk_fall) begin
            if (quad_mode_reg) begin
                // Two nibbles per byte on all four lines
                if (out_count_reg == 3'h0) begin
                    dq_out_reg <= status_byte[7:4];
                    out_shift_reg <= status_byte;
                    out_count_reg <= 3'h1;
                end else begin
                    dq_out_reg <= out_shift_reg[3:0];
                    out_count_reg <= 3'h0;
                end
                dq_oe_reg <= 4'hF;
            end else begin
                // One bit per falling edge on DQ1
                if (out_count_reg == 3'h0) begin
                    dq_out_reg <= {2'h0, status_byte[7], 1'b0};
                    out_shift_reg <= {status_byte[6:0], 1'b0};
                end else begin
                    dq_out_reg <= {2'h0, out_shift_reg[7], 1'b0};
                    out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                end
                out_count_reg <= out_count_reg + 3'h1;
                dq_oe_reg <= 4'h2;
            end
        end
    end
end

// ----------------------------------------------------------------------
// Command execution at the end of a frame
// ----------------------------------------------------------------------
always @(posedge clk_in) begin
    if (reset_in) begin
        protect_reg <= nv_reset_value[5];
        pin_disable_reg <= nv_reset_value[4];
        block_protect_reg <= nv_reset_value[3:0];
        write_enable_latch_reg <= 1'b0;
        otp_lock_reg <= 1'b0;
        otp_mode_reg <= 1'b0;
        quad_mode_reg <= 1'b0;
        opcode_reg <= 8'h00;
        grant_reg <= 1'b0;
        reject_reg <= 1'b0;
        write_status_cmd_start_reg <= 1'b0;
    end else begin
        grant_reg <= 1'b0;
        reject_reg <= 1'b0;
        write_status_cmd_start_reg <= 1'b0;
        if (opcode_strobe) begin
            opcode_reg <= rx_shift[7:0];
        end
        if (otp_enter_in) begin
            otp_mode_reg <= 1'b1;
        end
        // Array program and erase permission
        if (op_req_in) begin
            if (op_ok) begin
                grant_reg <= 1'b1;
            end else begin
                reject_reg <= 1'b1;
            end
        end
        // Completion of a timed status write or array operation
        if (write_status_cmd_done || array_done_in) begin
            write_enable_latch_reg <= 1'b0;
        end
        if (frame_opcode_only) begin
            if (is_opcode(rx_shift[7:0], `SFSP_OP_WRITE_ENABLE) && !busy_flag) begin
                write_enable_latch_reg <= 1'b1;
            end else if (is_opcode(rx_shift[7:0], `SFSP_OP_WRITE_DISABLE) && !busy_flag) begin
                if (otp_mode_reg) begin
                    otp_mode_reg <= 1'b0;
                end else begin
                    write_enable_latch_reg <= 1'b0;
                end
            end else if (is_opcode(rx_shift[7:0], `SFSP_OP_QUAD_ENTRY)) begin
                quad_mode_reg <= 1'b1;
            end else if (is_opcode(rx_shift[7:0], `SFSP_OP_QUAD_RESET) && quad_mode_reg) begin
                quad_mode_reg <= 1'b0;
            end
        end
        if (write_status_cmd_ok) begin
            write_status_cmd_start_reg <= 1'b1;
            if (otp_mode_reg) begin
                otp_lock_reg <= 1'b1;
            end else begin
                // Latch and busy bits of the data byte are dropped
                protect_reg <= rx_shift[`SFSP_BIT_PROTECT];
                pin_disable_reg <= rx_shift[`SFSP_BIT_PIN_DIS];
                block_protect_reg <= rx_shift[`SFSP_BP_HI:`SFSP_BP_LO];
            end
        end
    end
end

endmodule // sfsp_status_protect

// File: design/sfsp_defs.vh
/*
 * Constants of the flash status and protection block: opcodes, status bit
 * positions, reset values and the status write timing.
 * Assumes a 50 MHz system clock and inclusion by every design file.
 */
`ifndef SFSP_DEFS_VH
`define SFSP_DEFS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define SFSP_OP_WRITE_STATUS 8'h01
`define SFSP_OP_WRITE_DISABLE 8'h04
`define SFSP_OP_READ_STATUS 8'h05
`define SFSP_OP_WRITE_ENABLE 8'h06
`define SFSP_OP_QUAD_ENTRY 8'h38
`define SFSP_OP_QUAD_RESET 8'hFF

// ----------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------
`define SFSP_BIT_PROTECT 7
`define SFSP_BIT_PIN_DIS 6
`define SFSP_BP_HI 5
`define SFSP_BP_LO 2
`define SFSP_BIT_WEL 1
`define SFSP_BIT_BUSY 0
`define SFSP_NV_RESET 6'h00

// ----------------------------------------------------------------------
// Frame lengths in received bits
// ----------------------------------------------------------------------
`define SFSP_OPCODE_BITS 6'h08
`define SFSP_WRITE_STATUS_CMD_BITS 6'h10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFSP_CLK_MHZ 50
`define SFSP_STATUS_WRITE_TIME_US 5000
`define SFSP_STATUS_WRITE_CYCLES (`SFSP_STATUS_WRITE_TIME_US * `SFSP_CLK_MHZ)

`endif

// File: design/sfsp_link_rx.v
/*
 * Serial link receiver: finds serial clock edges, counts and shifts in
 * bits, one or four per rising edge, while chip select is low.
 * Assumes all link pins are synchronous to clk_in.
 */
`timescale 1ns/1ns
`include "sfsp_defs.vh"

module sfsp_link_rx (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Link pins
    input wire cs_n_in,
    input wire sclk_in,
    input wire [3:0] dq_in,
    input wire quad_in,
    // Decoded frame
    output wire [15:0] shift_out,
    output wire [5:0] bit_count_out,
    output wire opcode_strobe_out,
    output wire cs_rise_out,
    output wire sclk_fall_out
);

reg sclk_prev_reg;
reg cs_prev_reg;
reg [15:0] shift_reg;
reg [15:0] shift_next;
reg [5:0] count_reg;
reg [5:0] count_next;
reg strobe_reg;

wire sclk_rise;

assign sclk_rise = ~cs_n_in & sclk_in & ~sclk_prev_reg;
assign sclk_fall_out = ~cs_n_in & ~sclk_in & sclk_prev_reg;
assign cs_rise_out = cs_n_in & ~cs_prev_reg;
assign shift_out = shift_reg;
assign bit_count_out = count_reg;
assign opcode_strobe_out = strobe_reg;

// ----------------------------------------------------------------------
// Shift, most significant first
// ----------------------------------------------------------------------
always @* begin
    shift_next = shift_reg;
    count_next = count_reg;
    if (cs_n_in) begin
        count_next = 6'h00;
    end else if (sclk_rise) begin
        if (quad_in) begin
            shift_next = {shift_reg[11:0], dq_in};
            count_next = (count_reg > 6'h3B) ? 6'h3F : count_reg + 6'h04;
        end else begin
            shift_next = {shift_reg[14:0], dq_in[0]};
            count_next = (count_reg == 6'h3F) ? 6'h3F : count_reg + 6'h01;
        end
    end
end

always @(posedge clk_in) begin
    if (reset_in) begin
        sclk_prev_reg <= 1'b0;
        cs_prev_reg <= 1'b1;
        shift_reg <= 16'h0000;
        count_reg <= 6'h00;
        strobe_reg <= 1'b0;
    end else begin
        sclk_prev_reg <= sclk_in;
        cs_prev_reg <= cs_n_in;
        shift_reg <= shift_next;
        count_reg <= count_next;
        strobe_reg <= sclk_rise & (count_next == `SFSP_OPCODE_BITS) & (count_reg != `SFSP_OPCODE_BITS);
    end
end

endmodule // sfsp_link_rx

// File: design/sfsp_write_timer.v
/*
 * Self-timed status write cycle: busy for a fixed count after a start.
 * Assumes start pulses come only while idle.
 */
`timescale 1ns/1ns
`include "sfsp_defs.vh"

module sfsp_write_timer #(
    parameter [31:0] CYCLES = `SFSP_STATUS_WRITE_CYCLES
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Control
    input wire start_in,
    output wire busy_out,
    output wire done_out
);

reg [31:0] count_reg;

assign busy_out = (count_reg != 32'h00000000);
// Last busy cycle, so the latch clears as busy drops
assign done_out = (count_reg == 32'h00000001);

// ----------------------------------------------------------------------
// Down counter
// ----------------------------------------------------------------------
always @(posedge clk_in) begin
    if (reset_in) begin
        count_reg <= 32'h00000000;
    end else begin
        if (start_in && !busy_out) begin
            count_reg <= CYCLES;
        end else if (busy_out) begin
            count_reg <= count_reg - 32'h00000001;
        end
    end
end

endmodule // sfsp_write_timer

// File: dv/sfsp_props.sv
/* Checker of the flash status and protection block ports.
   Assumes a bind to sfsp_status_protect from the bench top. */
`timescale 1ns/1ns
module sfsp_props #(
    parameter [31:0] STATUS_WRITE_CYCLES = 32'd250000
) (
    // Clock, reset and link
    input wire clk_in, reset_in, cs_n_in, sclk_in,
    input wire [3:0] dq_in, dq_out, dq_oe_out,
    // Controls and status
    input wire hold_active_out, otp_enter_in, otp_mode_out, op_req_in, op_chip_erase_in,
    input wire op_hits_protect_in, op_otp_sector_in, op_grant_out, op_reject_out,
    input wire array_busy_in, array_done_in, quad_mode_out, hw_protect_out,
    input wire [7:0] status_out
);
    // ------------------------------
    // Status write busy length
    // ------------------------------
    reg [31:0] busy_cnt_reg;
    always @(posedge clk_in) begin
        if (reset_in || !status_out[0] || array_busy_in)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ------------------------------
    // Properties
    // ------------------------------
    busy_array_a: assert property (array_busy_in && $past(array_busy_in) |-> status_out[0])
        else $error("busy flag low during array run");
    busy_len_a: assert property ($fell(status_out[0]) && !$past(array_busy_in, 2)
        |-> $past(busy_cnt_reg) + 1 >= STATUS_WRITE_CYCLES && $past(busy_cnt_reg) <= STATUS_WRITE_CYCLES + 2)
        else $error("status write time off");
    wel_clear_a: assert property ($fell(status_out[0]) && !$past(array_busy_in, 2) |-> !status_out[1])
        else $error("latch kept after status write");
    wel_busy_a: assert property ($rose(status_out[0]) && !array_busy_in |-> status_out[1])
        else $error("status write ran without latch");
    grant_wel_a: assert property (op_grant_out |-> $past(status_out[1]))
        else $error("grant without latch");
    op_answer_a: assert property (op_req_in |=> op_grant_out != op_reject_out)
        else $error("no single answer to array request");
    chip_bp_a: assert property (op_req_in && op_chip_erase_in && status_out[5:2] != 4'h0 |=> op_reject_out)
        else $error("chip erase passed with protect bits");
    range_bp_a: assert property (op_req_in && op_hits_protect_in && status_out[5:2] != 4'h0 |=> op_reject_out)
        else $error("protected range not refused");
    hw_cause_a: assert property (hw_protect_out |-> !dq_in[2] && !quad_mode_out && !status_out[6])
        else $error("hardware protect without cause");
    hw_hold_a: assert property (hw_protect_out && $past(hw_protect_out) |-> $stable(status_out[7:2]))
        else $error("protected bits changed");
    hold_pin_a: assert property (hold_active_out |-> !dq_in[3] && !cs_n_in && !status_out[6] && !quad_mode_out)
        else $error("hold active without cause");
    oe_idle_a: assert property (cs_n_in && $past(cs_n_in) |-> dq_oe_out == 4'h0)
        else $error("data driven while deselected");
    oe_mode_a: assert property (dq_oe_out != 4'h0 |-> dq_oe_out == (quad_mode_out ? 4'hF : 4'h2))
        else $error("wrong drive lines");
    cover property ($fell(status_out[0]) && !$past(array_busy_in, 2));
    cover property (op_grant_out);
    cover property (dq_oe_out == 4'hF);
endmodule // sfsp_props

// File: dv/sfsp_host_model.sv
/* Host link model: select, serial clock and data lines, one or four bits a clock.
   Assumes clk_in at 50 MHz and a bench that resolves the shared data lines. */
`timescale 1ns/1ns
module sfsp_host_model (
    // Clock
    input wire clk_in,
    // Link
    output reg cs_n_out,
    output reg sclk_out,
    output wire [3:0] dq_out,
    input wire [3:0] dq_in
);
    reg quad;
    reg wp_n;
    reg hold_n;
    reg [3:0] dq_reg;
    assign dq_out = quad ? dq_reg : {hold_n, wp_n, dq_reg[1:0]};
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        quad = 1'b0;
        wp_n = 1'b1;
        hold_n = 1'b1;
        dq_reg = 4'h0;
    end
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_in);
            #2;
        end
    endtask
    task step(input [3:0] d, output [3:0] q);
        begin
            dq_reg = quad ? d : {2'b00, ~dq_reg[1], d[0]};
            cyc(2);
            q = dq_in;
            sclk_out = 1'b1;
            cyc(2);
            sclk_out = 1'b0;
            cyc(2);
        end
    endtask
    task frame(input [15:0] tx, input integer nb, input integer nr, output [15:0] rx);
        integer i;
        reg [3:0] q;
        begin
            rx = 16'h0000;
            cs_n_out = 1'b0;
            cyc(2);
            for (i = 0; i < nb; i = i + (quad ? 4 : 1))
                step(quad ? tx[15 - i -: 4] : {3'b000, tx[15 - i]}, q);
            for (i = 0; i < nr; i = i + 1) begin
                step(~dq_reg, q);
                rx = quad ? {rx[11:0], q} : {rx[14:0], q[1]};
            end
            cs_n_out = 1'b1;
            dq_reg = ~dq_reg;
            cyc(3);
        end
    endtask
endmodule // sfsp_host_model

// File: dv/tb.sv
/* Self-checking bench of the flash status and protection block.
   Assumes the host model and checker files from dv/. */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %h not %h", $time, g, e); end end
module tb;
    // ------------------------------
    // Signals and instances
    // ------------------------------
    reg clk_in, reset_in, otp_enter_in, op_req_in, op_chip_erase_in, op_hits_protect_in, op_otp_sector_in;
    reg array_busy_in, array_done_in;
    integer failures, num_checks, i;
    reg [15:0] rx;
    wire cs_n, sclk, hold_act, otp_mode, grant, reject, quad_mode, hw_prot;
    wire [3:0] host_dq, dut_dq, dut_oe, line_dq;
    wire [7:0] status;
    assign line_dq = (dut_oe & dut_dq) | (~dut_oe & host_dq);
    sfsp_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .dq_out(host_dq), .dq_in(line_dq));
    sfsp_status_protect #(.STATUS_WRITE_CYCLES(32'd400)) dut (.clk_in(clk_in), .reset_in(reset_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .dq_in(line_dq), .dq_out(dut_dq), .dq_oe_out(dut_oe),
        .hold_active_out(hold_act), .otp_enter_in(otp_enter_in), .otp_mode_out(otp_mode), .op_req_in(op_req_in),
        .op_chip_erase_in(op_chip_erase_in), .op_hits_protect_in(op_hits_protect_in),
        .op_otp_sector_in(op_otp_sector_in), .op_grant_out(grant), .op_reject_out(reject),
        .array_busy_in(array_busy_in), .array_done_in(array_done_in), .status_out(status),
        .quad_mode_out(quad_mode), .hw_protect_out(hw_prot));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // ------------------------------
    // Tasks
    // ------------------------------
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task cmd(input [7:0] op);
        host.frame({op, 8'h00}, 8, 0, rx);
    endtask
    task write_status_cmd(input [7:0] d);
        host.frame({8'h01, d}, 16, 0, rx);
    endtask
    task wait_idle;
        begin
            for (i = 0; i < 1000 && status[0] !== 1'b0; i++)
                host.cyc(1);
            if (i == 1000) begin
                failures++;
                report_and_stop;
            end
        end
    endtask
    task op(input ce, input hit, input otp, input exp);
        begin
            op_chip_erase_in = ce;
            op_hits_protect_in = hit;
            op_otp_sector_in = otp;
            op_req_in = 1'b1;
            host.cyc(1);
            op_req_in = 1'b0;
            `CHK({grant, reject}, {exp, ~exp})
        end
    endtask
    task done(input [8*8-1:0] name);
        $display("test %0s done", name);
    endtask
    // ------------------------------
    // Sequence
    // ------------------------------
    initial begin
        reset_in = 1'b1;
        otp_enter_in = 1'b0;
        op_req_in = 1'b0;
        op_chip_erase_in = 1'b0;
        op_hits_protect_in = 1'b0;
        op_otp_sector_in = 1'b0;
        array_busy_in = 1'b0;
        array_done_in = 1'b0;
        failures = 0;
        num_checks = 0;
        host.cyc(8);
        reset_in = 1'b0;
        host.cyc(2);
        `CHK({status, dut_oe}, 12'h000)
        host.frame(16'h0600, 4, 0, rx);
        `CHK(status, 8'h00)
        cmd(8'h06);
        `CHK(status, 8'h02)
        host.frame(16'h0500, 8, 16, rx);
        `CHK(rx, 16'h0202)
        cmd(8'h04);
        `CHK(status, 8'h00)
        done("basic");
        write_status_cmd(8'hFF);
        `CHK(status, 8'h00)
        cmd(8'h06);
        host.frame(16'h01FF, 12, 0, rx);
        `CHK(status, 8'h02)
        write_status_cmd(8'h3C);
        `CHK(status, 8'h3F)
        host.frame(16'h0500, 8, 8, rx);
        `CHK(rx[7:0], 8'h3F)
        wait_idle;
        `CHK(status, 8'h3C)
        done("write_status_cmd");
        op(1'b0, 1'b0, 1'b0, 1'b0);
        cmd(8'h06);
        op(1'b0, 1'b1, 1'b0, 1'b0);
        op(1'b1, 1'b0, 1'b0, 1'b0);
        write_status_cmd(8'h00);
        wait_idle;
        `CHK(status, 8'h00)
        cmd(8'h06);
        op(1'b1, 1'b0, 1'b0, 1'b1);
        array_busy_in = 1'b1;
        host.cyc(2);
        `CHK(status, 8'h03)
        array_busy_in = 1'b0;
        array_done_in = 1'b1;
        host.cyc(1);
        array_done_in = 1'b0;
        host.cyc(1);
        `CHK(status, 8'h00)
        done("array");
        cmd(8'h06);
        write_status_cmd(8'h80);
        wait_idle;
        `CHK(status, 8'h80)
        host.wp_n = 1'b0;
        host.cyc(1);
        `CHK(hw_prot, 1'b1)
        cmd(8'h06);
        write_status_cmd(8'h00);
        `CHK(status, 8'h82)
        host.wp_n = 1'b1;
        write_status_cmd(8'h00);
        wait_idle;
        `CHK(status, 8'h00)
        done("hwprot");
        host.hold_n = 1'b0;
        host.cs_n_out = 1'b0;
        host.cyc(1);
        `CHK(hold_act, 1'b1)
        host.cs_n_out = 1'b1;
        host.hold_n = 1'b1;
        host.cyc(2);
        cmd(8'h06);
        write_status_cmd(8'h40);
        wait_idle;
        host.hold_n = 1'b0;
        host.cs_n_out = 1'b0;
        host.cyc(1);
        `CHK({hold_act, status}, 9'h040)
        host.cs_n_out = 1'b1;
        host.hold_n = 1'b1;
        host.cyc(2);
        cmd(8'h06);
        write_status_cmd(8'h00);
        wait_idle;
        otp_enter_in = 1'b1;
        host.cyc(1);
        otp_enter_in = 1'b0;
        host.cyc(1);
        cmd(8'h06);
        write_status_cmd(8'h3C);
        wait_idle;
        `CHK({otp_mode, status}, 9'h180)
        cmd(8'h06);
        op(1'b0, 1'b0, 1'b1, 1'b0);
        cmd(8'h04);
        `CHK({otp_mode, status}, 9'h002)
        done("otp");
        cmd(8'h38);
        host.quad = 1'b1;
        cmd(8'h04);
        `CHK({quad_mode, status}, 9'h100)
        cmd(8'h06);
        host.frame(16'h0500, 8, 4, rx);
        `CHK(rx, 16'h0202)
        cmd(8'hFF);
        host.quad = 1'b0;
        `CHK(quad_mode, 1'b0)
        reset_in = 1'b1;
        host.cyc(2);
        reset_in = 1'b0;
        host.cyc(1);
        `CHK(status, 8'h00)
        done("quad");
        report_and_stop;
    end
endmodule // tb
bind sfsp_status_protect sfsp_props #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) props (.clk_in(clk_in),
    .reset_in(reset_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .hold_active_out(hold_active_out), .otp_enter_in(otp_enter_in),
    .otp_mode_out(otp_mode_out), .op_req_in(op_req_in), .op_chip_erase_in(op_chip_erase_in),
    .op_hits_protect_in(op_hits_protect_in), .op_otp_sector_in(op_otp_sector_in), .op_grant_out(op_grant_out),
    .op_reject_out(op_reject_out), .array_busy_in(array_busy_in), .array_done_in(array_done_in),
    .quad_mode_out(quad_mode_out), .hw_protect_out(hw_protect_out), .status_out(status_out));
